// ===== logic/sef_pkg.sv
// Package of the serial memory bus front end: constants, states and carriers.
// Assumes a single 250 MHz core clock and no register bus.
package sef_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 4000; // Core clock period in ps
  localparam int PROG_TIME_MS = 5; // Longest self-timed program time in ms
  // Longest time rounds down to whole cycles; worked in ns so the product stays inside 32 bits
  localparam int PROG_CYCLES = (PROG_TIME_MS * 1_000_000) / (CLK_PERIOD_PS / 1_000);
  localparam int PROG_CNT_W = 21; // Wide enough for the program count

  // ----------------------------------------------------------------
  // Word layout
  // ----------------------------------------------------------------
  localparam int WORD_BITS = 8; // Bits in every bus word
  localparam int TYPE_MSB = 7; // Type identifier upper bit
  localparam int TYPE_LSB = 4; // Type identifier lower bit
  localparam int SEL_MSB = 3; // Hardware select upper bit
  localparam int SEL_LSB = 1; // Hardware select lower bit
  localparam int DIR_BIT = 0; // Direction select bit, one reads
  localparam logic [3:0] BIT_CNT_RST = 4'h0; // Bit counter reset value
  localparam logic [3:0] BIT_CNT_FULL = 4'h8; // Count after a whole word
  localparam logic [7:0] SHIFT_RST = 8'h00; // Shift register reset value

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  // Protocol states
  typedef enum logic [2:0] {
    ST_STANDBY = 3'b000, // Idle, low power
    ST_ADDR = 3'b001, // Shifting in the device address word
    ST_ACK = 3'b010, // Ninth clock after a received word
    ST_WDATA = 3'b011, // Shifting in a write word
    ST_RDATA = 3'b100, // Shifting out a read word
    ST_RACK = 3'b101, // Ninth clock of a read word, controller answers
    ST_WAIT = 3'b110 // Released, waiting for start or stop
  } sef_state_e;

  // Sampled bus lines
  typedef struct packed {
    logic scl; // Serial clock level
    logic sda; // Serial data level
  } sef_line_s;

  // Edge and condition events of one core cycle
  typedef struct packed {
    logic scl_rise; // Clock rising edge
    logic scl_fall; // Clock falling edge
    logic start; // Data falls with clock high
    logic stop; // Data rises with clock high
  } sef_evt_s;

endpackage

// ===== logic/sef_front_end.sv
// Two-wire bus target front end of a serial byte memory.
// Assumes the bus clock and data pins are asynchronous to core_clk and much
// slower; the user side is on core_clk and supplies read bytes on request.
`timescale 1ns/1ps

module sef_front_end #(
  parameter logic [3:0] TYPE_ID = 4'h6, // Memory type identifier, value arbitrary
  parameter int PROG_CYCLES = sef_pkg::PROG_CYCLES // Program cycle length in core cycles
) (
  input wire logic core_clk, // Core clock, 250 MHz
  input wire logic arst_n, // Asynchronous reset, active low
  input wire logic scl_i, // Serial clock pin level
  input wire logic sda_i, // Serial data pin level
  output logic sda_o, // Serial data output level, always low
  output logic sda_oe_n, // Serial data enable, low while pulling low
  input wire logic hw_select_strap_2, // Hardware select strap, bit 3
  input wire logic hw_select_strap_1, // Hardware select strap, bit 2
  input wire logic hw_select_strap_0, // Hardware select strap, bit 1
  input wire logic write_protect_i, // High inhibits writes
  input wire logic [7:0] tx_data_i, // Next read byte from the array side
  output logic tx_req_o, // Pulse: tx_data_i taken
  output logic [7:0] rx_data_o, // Last received write byte, loaded even while write protected
  output logic rx_valid_o, // Pulse: rx_data_o holds a new write byte
  output logic read_mode_o, // Selected for reading
  output logic selected_o, // Address matched, transaction open
  output logic busy_o, // Self-timed program cycle running
  output logic standby_o // Low-power standby
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  sef_pkg::sef_line_s meta_q; // First stage, read only by stage two
  sef_pkg::sef_line_s sync_q; // Second stage
  sef_pkg::sef_line_s prev_q; // Previous synced level for edges
  sef_pkg::sef_evt_s evt; // Events of this cycle

  // Two flip-flops per pin, then a delay stage for edge finding
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_q <= '1;
      sync_q <= '1;
      prev_q <= '1;
    end else begin
      meta_q <= '{scl: scl_i, sda: sda_i};
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  // Edge and condition decode
  always_comb begin
    evt.scl_rise = sync_q.scl & ~prev_q.scl;
    evt.scl_fall = ~sync_q.scl & prev_q.scl;
    // Data moving while clock stays high is never a data bit
    evt.start = sync_q.scl & prev_q.scl & prev_q.sda & ~sync_q.sda;
    evt.stop = sync_q.scl & prev_q.scl & ~prev_q.sda & sync_q.sda;
  end

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  // True when a device address word selects this target
  function automatic logic addr_hit(input logic [7:0] w, input logic [2:0] strap, input logic [3:0] tid);
    logic type_ok;
    logic sel_ok;
    type_ok = (w[sef_pkg::TYPE_MSB:sef_pkg::TYPE_LSB] == tid);
    sel_ok = (w[sef_pkg::SEL_MSB:sef_pkg::SEL_LSB] == strap);
    return type_ok & sel_ok;
  endfunction

  logic [2:0] strap; // Strap levels in address bit order
  assign strap = {hw_select_strap_2, hw_select_strap_1, hw_select_strap_0};

  // ----------------------------------------------------------------
  // Protocol engine
  // ----------------------------------------------------------------
  sef_pkg::sef_state_e state_q, state_d; // Protocol state
  logic [3:0] cnt_q, cnt_d; // Rising edges seen in this word
  logic [7:0] shift_q, shift_d; // Word shift register
  logic drive_q, drive_d; // Pull data low
  logic addr_phase_q, addr_phase_d; // ACK state follows the address word
  logic read_q, read_d; // Selected for reading
  logic sel_q, sel_d; // Address matched
  logic pend_q, pend_d; // Write word accepted, program due at stop
  logic mack_q, mack_d; // Controller acknowledged the read word
  logic [7:0] rx_q, rx_d; // Received write byte, loaded even while protected
  logic rxv_q, rxv_d; // Write byte strobe
  logic txr_q, txr_d; // Read byte request strobe
  logic prog_go; // Start of the self-timed program
  logic busy_q; // Program cycle running

  // Next-state logic of the engine
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    shift_d = shift_q;
    drive_d = drive_q;
    addr_phase_d = addr_phase_q;
    read_d = read_q;
    sel_d = sel_q;
    pend_d = pend_q;
    mack_d = mack_q;
    rx_d = rx_q;
    rxv_d = 1'b0;
    txr_d = 1'b0;
    prog_go = 1'b0;
    if (busy_q) begin
      // Inputs ignored and data released while programming
      state_d = sef_pkg::ST_STANDBY;
      drive_d = 1'b0;
      sel_d = 1'b0;
      read_d = 1'b0;
    end else if (evt.start) begin
      // Any start outside programming, even mid word, restarts address reception
      state_d = sef_pkg::ST_ADDR;
      cnt_d = sef_pkg::BIT_CNT_RST;
      drive_d = 1'b0;
      sel_d = 1'b0;
      read_d = 1'b0;
      pend_d = 1'b0;
    end else if (evt.stop) begin
      // Stop ends the transaction; standby once nothing runs
      state_d = sef_pkg::ST_STANDBY;
      drive_d = 1'b0;
      sel_d = 1'b0;
      read_d = 1'b0;
      pend_d = 1'b0;
      prog_go = pend_q; // Self-timed cycle follows a write
    end else begin
      case (state_q)
        sef_pkg::ST_STANDBY: begin
          // Only a start leaves standby
          drive_d = 1'b0;
        end
        sef_pkg::ST_ADDR, sef_pkg::ST_WDATA: begin
          if (evt.scl_rise) begin
            // Sample on the rising clock, first bit most significant
            shift_d = {shift_q[6:0], sync_q.sda};
            cnt_d = cnt_q + 4'h1;
          end else if (evt.scl_fall && cnt_q == sef_pkg::BIT_CNT_FULL) begin
            // Eighth bit done: ninth clock belongs to the acknowledge
            state_d = sef_pkg::ST_ACK;
            cnt_d = sef_pkg::BIT_CNT_RST;
            addr_phase_d = (state_q == sef_pkg::ST_ADDR);
            if (state_q == sef_pkg::ST_ADDR) begin
              if (addr_hit(shift_q, strap, TYPE_ID)) begin
                drive_d = 1'b1; // Matched address acknowledged
                sel_d = 1'b1;
                read_d = shift_q[sef_pkg::DIR_BIT]; // One reads, zero writes
              end else begin
                drive_d = 1'b0; // No acknowledge on mismatch
              end
            end else begin
              drive_d = 1'b1; // Data word acknowledged
              rx_d = shift_q;
              // Protected array takes no write and starts no program
              rxv_d = ~write_protect_i;
              pend_d = pend_q | ~write_protect_i;
            end
          end
        end
        sef_pkg::ST_ACK: begin
          if (evt.scl_fall) begin
            // Release after the ninth clock falls
            drive_d = 1'b0;
            if (!sel_q) begin
              state_d = sef_pkg::ST_STANDBY; // Unselected, back to standby
            end else if (addr_phase_q && read_q) begin
              // First read word: take it and drive its top bit
              state_d = sef_pkg::ST_RDATA;
              shift_d = tx_data_i;
              txr_d = 1'b1;
              drive_d = ~tx_data_i[7];
            end else begin
              state_d = sef_pkg::ST_WDATA;
            end
          end
        end
        sef_pkg::ST_RDATA: begin
          if (evt.scl_rise) begin
            cnt_d = cnt_q + 4'h1;
          end else if (evt.scl_fall) begin
            if (cnt_q == sef_pkg::BIT_CNT_FULL) begin
              // Word sent, release for the controller's answer
              state_d = sef_pkg::ST_RACK;
              cnt_d = sef_pkg::BIT_CNT_RST;
              drive_d = 1'b0;
            end else begin
              // Next bit changes only with the clock low
              shift_d = {shift_q[6:0], 1'b0};
              drive_d = ~shift_q[6];
            end
          end
        end
        sef_pkg::ST_RACK: begin
          if (evt.scl_rise) begin
            mack_d = ~sync_q.sda; // Low means continue
          end else if (evt.scl_fall) begin
            if (mack_q) begin
              state_d = sef_pkg::ST_RDATA;
              shift_d = tx_data_i;
              txr_d = 1'b1;
              drive_d = ~tx_data_i[7];
            end else begin
              state_d = sef_pkg::ST_WAIT; // No acknowledge: wait for start or stop
            end
          end
        end
        sef_pkg::ST_WAIT: begin
          drive_d = 1'b0;
        end
        default: begin
          state_d = sef_pkg::ST_STANDBY;
          drive_d = 1'b0;
        end
      endcase
    end
  end

  // Engine registers
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= sef_pkg::ST_STANDBY; // Standby after power-up
      cnt_q <= sef_pkg::BIT_CNT_RST;
      shift_q <= sef_pkg::SHIFT_RST;
      drive_q <= 1'b0;
      addr_phase_q <= 1'b0;
      read_q <= 1'b0;
      sel_q <= 1'b0;
      pend_q <= 1'b0;
      mack_q <= 1'b0;
      rx_q <= sef_pkg::SHIFT_RST;
      rxv_q <= 1'b0;
      txr_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      shift_q <= shift_d;
      drive_q <= drive_d;
      addr_phase_q <= addr_phase_d;
      read_q <= read_d;
      sel_q <= sel_d;
      pend_q <= pend_d;
      mack_q <= mack_d;
      rx_q <= rx_d;
      rxv_q <= rxv_d;
      txr_q <= txr_d;
    end
  end

  // ----------------------------------------------------------------
  // Self-timed program cycle
  // ----------------------------------------------------------------
  logic [sef_pkg::PROG_CNT_W-1:0] prog_q, prog_d; // Cycles left
  logic busy_d; // Next busy level
  localparam logic [sef_pkg::PROG_CNT_W-1:0] PROG_LOAD = sef_pkg::PROG_CNT_W'(PROG_CYCLES - 1);

  // Count down from stop to end of programming
  always_comb begin
    prog_d = prog_q;
    busy_d = busy_q;
    if (prog_go) begin
      prog_d = PROG_LOAD;
      busy_d = 1'b1;
    end else if (busy_q) begin
      if (prog_q == '0) begin
        busy_d = 1'b0; // Programming finished, standby follows
      end else begin
        prog_d = prog_q - 1'b1;
      end
    end
  end

  // Program counter registers
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      prog_q <= '0;
      busy_q <= 1'b0;
    end else begin
      prog_q <= prog_d;
      busy_q <= busy_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign sda_o = 1'b0; // Open drain: only ever pulls low
  assign sda_oe_n = ~drive_q; // Enable low while pulling
  assign tx_req_o = txr_q;
  assign rx_data_o = rx_q;
  assign rx_valid_o = rxv_q;
  assign read_mode_o = read_q;
  assign selected_o = sel_q;
  assign busy_o = busy_q;
  assign standby_o = (state_q == sef_pkg::ST_STANDBY) & ~busy_q;

endmodule

// ===== verif/sef_front_end_monitor.sv
// Port checker of the serial memory bus front end.
// Assumes binding to sef_front_end, one core clock domain.
`timescale 1ns/1ps
module sef_front_end_monitor #(
  parameter int PROG_CYCLES = 200 // Program length in core cycles
) (
  input wire logic core_clk, // Core clock
  input wire logic arst_n, // Reset, active low
  input wire logic scl_i, // Bus clock pin
  input wire logic sda_i, // Bus data wire
  input wire logic sda_oe_n, // Data pull enable, low pulls
  input wire logic write_protect_i, // Write protect
  input wire logic tx_req_o, // Read byte taken
  input wire logic rx_valid_o, // Write byte pulse
  input wire logic read_mode_o, // Read selected
  input wire logic selected_o, // Transaction open
  input wire logic busy_o, // Program running
  input wire logic standby_o // Standby
);
  // ----------------------------------------------------------------
  // Busy length counter
  // ----------------------------------------------------------------
  logic [sef_pkg::PROG_CNT_W-1:0] cnt_q; // Busy cycles so far
  logic [sef_pkg::PROG_CNT_W-1:0] cnt_d; // Next count
  // Counts while busy, clears otherwise
  always_comb begin
    cnt_d = busy_o ? cnt_q + 1'b1 : '0;
  end
  // Registers the count
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end
  // ----------------------------------------------------------------
  // Bus conditions and assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  // Data falls while the clock stays high
  sequence start_seq;
    scl_i && $past(scl_i) && $fell(sda_i);
  endsequence
  // Data rises while the clock stays high
  sequence stop_seq;
    scl_i && $past(scl_i) && $rose(sda_i);
  endsequence
  a_start_drops_sel: assert property (start_seq |-> ##[1:6] !selected_o)
    else $error("select kept over a start");
  a_stop_drops_sel: assert property (stop_seq |-> ##[1:6] !selected_o)
    else $error("select kept over a stop");
  a_read_stop_idle: assert property (((selected_o && read_mode_o) and stop_seq) |-> ##[1:6] standby_o)
    else $error("no standby after read stop");
  a_drive_clk_low: assert property ($changed(sda_oe_n) |-> !scl_i)
    else $error("data drive changed with clock high");
  a_busy_no_ack: assert property (busy_o |-> sda_oe_n)
    else $error("data pulled while busy");
  a_busy_not_idle: assert property (busy_o |-> !standby_o)
    else $error("standby while busy");
  a_busy_length: assert property ($fell(busy_o) |-> cnt_q == sef_pkg::PROG_CNT_W'(PROG_CYCLES))
    else $error("program length wrong");
  a_idle_after: assert property ($fell(busy_o) |-> ##[0:2] standby_o)
    else $error("no standby after program");
  a_rx_unprot: assert property (rx_valid_o |-> !write_protect_i)
    else $error("write byte while protected");
  a_rx_acked: assert property (rx_valid_o |-> ##[0:2] !sda_oe_n)
    else $error("write byte not acknowledged");
  a_tx_in_read: assert property (tx_req_o |-> read_mode_o && selected_o)
    else $error("read byte outside read");
endmodule

// ===== verif/sef_ctl_model.sv
// Bus controller model: makes the bus clock and pulls the data line.
// Assumes a pull-up on data; the bench resolves the wire.
`timescale 1ns/1ps
module sef_ctl_model (
  input wire logic core_clk, // Paces the bus
  input wire logic sda_w, // Resolved data wire
  output logic scl, // Bus clock, high when idle
  output logic sda // Data pull, one releases
);
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end
  // Waits whole core cycles plus a small offset
  task automatic tk(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  // Start, also repeated; waits out a device acknowledge first
  task automatic start_c();
    sda = 1'b1;
    tk(5);
    scl = 1'b1;
    tk(3);
    sda = 1'b0;
    tk(3);
    scl = 1'b0;
    tk(1);
  endtask
  // Stop from clock low
  task automatic stop_c();
    sda = 1'b0;
    tk(5);
    scl = 1'b1;
    tk(3);
    sda = 1'b1;
    tk(4);
  endtask
  // One clock of 32 ns: data set while low, sampled while high
  task automatic bit_x(input logic b, output logic s);
    sda = b;
    tk(5);
    scl = 1'b1;
    tk(1);
    s = sda_w;
    tk(1);
    scl = 1'b0;
    tk(1);
  endtask
  // Word then the ninth clock
  task automatic word_x(input logic [7:0] d, input logic a, output logic [7:0] q, output logic ak);
    for (int i = 7; i >= 0; i--) bit_x(d[i], q[i]);
    bit_x(a, ak);
  endtask
endmodule

// ===== verif/sef_front_end_bench.sv
// Self-checking bench of the bus front end.
// Assumes the front end, its package, the controller model and checker.
`timescale 1ns/1ps
`define SEF_CHK(n, e, g) chk(n, 8'(e), 8'(g))
module sef_front_end_bench;
  localparam logic [3:0] TID = 4'h9; // Type identifier, value arbitrary
  localparam int PCYC = 200; // Shortened program length
  logic core_clk = 1'b0; // Core clock
  logic arst_n; // Reset, active low
  logic wp; // Write protect
  logic [2:0] strap; // Select straps
  logic [7:0] tx; // Read byte offered
  logic [15:0] rnd = 16'hDB61; // Random state
  logic scl, ctl_sda, sda_w, sda_o, sda_oe_n; // Bus
  logic tx_req, rx_valid, read_mode, selected, busy, standby; // Status
  logic [7:0] rx_data; // Write byte
  logic [7:0] q; // Word seen by the controller
  logic ak; // Ninth clock level
  logic [7:0] exp_q[$]; // Expected write bytes
  int failures = 0;
  int checked = 0;
  int txn = 0; // Read byte requests seen
  always #2 core_clk = ~core_clk;
  assign sda_w = ctl_sda & (sda_oe_n | sda_o);
  sef_front_end #(.TYPE_ID(TID), .PROG_CYCLES(PCYC)) u_dut (.core_clk(core_clk), .arst_n(arst_n),
    .scl_i(scl), .sda_i(sda_w), .sda_o(sda_o), .sda_oe_n(sda_oe_n), .hw_select_strap_2(strap[2]),
    .hw_select_strap_1(strap[1]), .hw_select_strap_0(strap[0]), .write_protect_i(wp), .tx_data_i(tx),
    .tx_req_o(tx_req), .rx_data_o(rx_data), .rx_valid_o(rx_valid), .read_mode_o(read_mode),
    .selected_o(selected), .busy_o(busy), .standby_o(standby));
  sef_ctl_model u_ctl (.core_clk(core_clk), .sda_w(sda_w), .scl(scl), .sda(ctl_sda));
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (e !== g) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {1'b0, s[15:1]} ^ (s[0] ? 16'hB400 : 16'h0000);
  endfunction
  // Start, address word, acknowledge level
  task automatic addr(input logic [7:0] a, input logic e);
    u_ctl.start_c();
    u_ctl.word_x(a, 1'b1, q, ak);
    `SEF_CHK("addr ack", e, ak);
  endtask
  // Write word, noted when unprotected
  task automatic wr(input logic [7:0] d);
    if (!wp) exp_q.push_back(d);
    u_ctl.word_x(d, 1'b1, q, ak);
    `SEF_CHK("data ack", 1'b0, ak);
  endtask
  // Bounded wait for the end of programming
  task automatic idle();
    int n;
    n = 0;
    u_ctl.tk(4);
    while (busy !== 1'b0 && n < 2000) begin
      u_ctl.tk(1);
      n++;
    end
    `SEF_CHK("standby", 1'b1, standby);
  endtask
  task automatic stop_test();
    $display("Counts: %0d checked, %0d failures", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // Each write byte pulse takes the oldest note
  // Counts read byte requests, looked at mid cycle where the pulse is settled
  always @(negedge core_clk) begin
    if (tx_req === 1'b1) begin
      txn++;
    end
  end
  // Write bytes are looked at mid cycle, away from the launching edge
  always @(negedge core_clk) begin
    if (rx_valid === 1'b1) begin
      `SEF_CHK("rx data", exp_q.size() ? exp_q.pop_front() : 8'hxx, rx_data);
    end
  end
  initial begin
    #100us;
    failures++;
    $display("Watchdog expired");
    stop_test();
  end
  initial begin
    arst_n = 1'b0;
    wp = 1'b0;
    strap = 3'b000;
    tx = 8'h00;
    repeat (6) @(posedge core_clk);
    #1;
    arst_n = 1'b1;
    u_ctl.tk(4);
    `SEF_CHK("reset standby", 1'b1, standby);
    for (int k = 0; k < 2; k++) begin
      rnd = lfsr(rnd);
      strap = (k == 0) ? rnd[2:0] : 3'b000;
      addr({TID, strap, 1'b0}, 1'b0);
      wr(rnd[15:8]);
      rnd = lfsr(rnd);
      wr(rnd[7:0]);
      u_ctl.stop_c();
      u_ctl.tk(2);
      `SEF_CHK("busy", 1'b1, busy);
      addr({TID, strap, 1'b0}, 1'b1);
      u_ctl.stop_c();
      idle();
      $display("Test write done");
      tx = rnd[15:8];
      addr({TID, strap, 1'b1}, 1'b0);
      `SEF_CHK("read mode", 1'b1, read_mode);
      `SEF_CHK("selected", 1'b1, selected);
      u_ctl.word_x(8'hFF, 1'b1, q, ak);
      `SEF_CHK("read byte", tx, q);
      u_ctl.stop_c();
      u_ctl.tk(2);
      `SEF_CHK("read standby", 2'b10, {standby, busy});
      $display("Test read done");
      for (int b = 1; b < 8; b++) begin
        addr({TID, strap, 1'b0} ^ (8'h01 << b), 1'b1);
        u_ctl.stop_c();
      end
      $display("Test mismatch done");
    end
    wp = 1'b1;
    addr({TID, strap, 1'b0}, 1'b0);
    wr(8'h5A);
    u_ctl.stop_c();
    u_ctl.tk(2);
    `SEF_CHK("protected busy", 1'b0, busy);
    addr({TID, strap, 1'b0}, 1'b0);
    for (int i = 0; i < 4; i++) u_ctl.bit_x(1'b0, ak);
    addr({TID, strap, 1'b0}, 1'b0);
    u_ctl.start_c();
    for (int i = 0; i < 9; i++) u_ctl.bit_x(1'b1, ak);
    u_ctl.start_c();
    u_ctl.stop_c();
    idle();
    wp = 1'b0;
    addr({TID, strap, 1'b0}, 1'b0);
    rnd = lfsr(rnd);
    wr(rnd[7:0]);
    u_ctl.stop_c();
    idle();
    $display("Test recovery done");
    `SEF_CHK("rx pending", 0, exp_q.size());
    `SEF_CHK("read requests", 2, txn);
    stop_test();
  end
endmodule
bind sef_front_end sef_front_end_monitor #(.PROG_CYCLES(PROG_CYCLES)) u_mon (.core_clk(core_clk),
  .arst_n(arst_n), .scl_i(scl_i), .sda_i(sda_i), .sda_oe_n(sda_oe_n), .write_protect_i(write_protect_i),
  .tx_req_o(tx_req_o), .rx_valid_o(rx_valid_o), .read_mode_o(read_mode_o), .selected_o(selected_o),
  .busy_o(busy_o), .standby_o(standby_o));
